// *** rtl/cmc_map.vh ***
// Constants for the charger mode controller
// Overview of operation
// - Leave ship after input valid or ship pin low for over 32 ms
// - Always pass through idle hold before charge or OTG mode
// - Enter ship when input and battery both fall below 1 V
// - Ship request bit stays set for 1 s, then ship entered, bit cleared
// - Writing 0 to ship request before 1 s cancels pending entry
// - Ship pin high for 32 ms enters ship at once, no delay
// - Ship pin tied low: start in ship, after 32 ms go idle hold
// - Idle hold keeps converter off; aux regulator follows its enable bit
// - Stay in idle hold while no mode is enabled
// - Return to idle hold on mode disable or idle hold bit set
// - Over 160 C disables converter and latches thermal fault flag
// - Converter restarts below 130 C; thermal flag clears on read
// - Switch over current limit turns switch off for that cycle
// - Eight consecutive limit cycles latch converter off in either mode
// - Latch cleared by disable bit or idle hold; bit disables latch-off
// - Host kicks watchdog; on expiry fault state, converter disabled
// - Each kick restarts watchdog timer; kick bit self-clears
// - Timeout field selects 80 s to 320 s; 00 disables watchdog
// - Watchdog off and cleared in idle hold; starts on active entry
// - Charge only entered from idle hold; OTG wins simultaneous request
// - Charge request from enable pin high or override bit set
// - Idle hold bit set blocks charge and OTG modes
// - In charge only pin+override low, idle hold bit, watchdog expiry, or ship end it
`ifndef CMC_MAP_VH
`define CMC_MAP_VH
`define CMC_CLK_HZ 100000000
`define CMC_QUAL_MS 32
`define CMC_QUAL_CYC (`CMC_CLK_HZ / 1000 * `CMC_QUAL_MS)
`define CMC_SHIP_DLY_S 1
`define CMC_SHIP_DLY_CYC (`CMC_CLK_HZ * `CMC_SHIP_DLY_S)
`define CMC_WDT_UNIT_S 80
// Sized factor keeps the product in 40 bits; 32-bit integer math would wrap
`define CMC_WDT_UNIT_CYC (40'd1 * `CMC_CLK_HZ * `CMC_WDT_UNIT_S)
`define CMC_OC_TRIPS 4'h8
`define CMC_ST_SHIP 3'h0
`define CMC_ST_IDLE 3'h1
`define CMC_ST_CHARGE 3'h2
`define CMC_ST_OTG 3'h3
`define CMC_ST_FAULT 3'h4
`define CMC_WDT_OFF 2'h0
`endif

// *** rtl/cmc_qual.v ***
// Continuous-level qualifier: pulses once a level has held a full interval
`timescale 1ns/1ps
module cmc_qual #(
  parameter [31:0] CYCLES = 32'd3200000
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire level_in,
  output reg done_out
);
  reg [31:0] count;
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count <= 32'h0;
      done_out <= 1'b0;
    end
    else if (ce_in)
    begin
      done_out <= 1'b0;
      if (!level_in)
        count <= 32'h0;
      else if (count < CYCLES)
      begin
        count <= count + 32'h1;
        // One pulse per qualified interval; held level does not retrigger
        if (count == CYCLES - 32'h1)
          done_out <= 1'b1;
      end
    end
  end
endmodule

// *** rtl/cmc_top.v ***
// Operating-mode controller for a battery charger
`timescale 1ns/1ps
`include "cmc_map.vh"
module cmc_top #(
  parameter [31:0] QUAL_CYCLES = `CMC_QUAL_CYC,
  parameter [31:0] SHIP_DLY_CYCLES = `CMC_SHIP_DLY_CYC,
  parameter [39:0] WDT_UNIT_CYCLES = `CMC_WDT_UNIT_CYC
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire vin_valid_in,
  input wire supplies_low_in,
  input wire ship_pin_in,
  input wire charge_enable_pin_in,
  input wire otg_request_pin_n_in,
  input wire otg_request_bit_in,
  input wire charge_override_bit_in,
  input wire idle_hold_bit_in,
  input wire ship_request_wr_in,
  input wire ship_request_wdata_in,
  input wire watchdog_kick_wr_in,
  input wire [1:0] watchdog_timeout_field_in,
  input wire regulator_enable_bit_in,
  input wire switch_limit_select_in,
  input wire overcurrent_latch_disable_in,
  input wire over_temp_in,
  input wire temp_recovered_in,
  input wire thermal_flag_rd_in,
  input wire cycle_end_in,
  input wire sw_current_85_in,
  input wire sw_current_10_in,
  output reg [2:0] mode_out,
  output reg converter_enable_out,
  output reg switch_off_out,
  output reg aux_regulator_enable_out,
  output reg ship_request_bit_out,
  output reg watchdog_kick_bit_out,
  output reg watchdog_expired_out,
  output reg thermal_fault_flag_out,
  output reg overcurrent_latch_out
);
  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] ship_count;
  reg [41:0] wdt_count;
  reg [3:0] oc_run;
  reg thermal_hold;
  reg cycle_tripped;
  wire vin_qual;
  wire pin_low_qual;
  wire pin_high_qual;
  wire limit_hit;
  wire charge_request;
  wire otg_request;
  wire ship_fire;
  wire wdt_fire;
  wire wdt_enabled;

  // Converts the timeout code to a cycle count, 01/10/11 = 1x/2x/4x unit
  function [41:0] wdt_limit;
    input [1:0] code;
    begin
      case (code)
        2'h1: wdt_limit = {2'h0, WDT_UNIT_CYCLES};
        2'h2: wdt_limit = {1'b0, WDT_UNIT_CYCLES, 1'b0};
        2'h3: wdt_limit = {WDT_UNIT_CYCLES, 2'h0};
        default: wdt_limit = 42'h0;
      endcase
    end
  endfunction

  function is_active;
    input [2:0] st;
    begin
      is_active = (st == `CMC_ST_CHARGE) || (st == `CMC_ST_OTG);
    end
  endfunction

  cmc_qual #(
    .CYCLES(QUAL_CYCLES)
  ) u_vin_qual (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .level_in(vin_valid_in),
    .done_out(vin_qual)
  );

  cmc_qual #(
    .CYCLES(QUAL_CYCLES)
  ) u_pin_low_qual (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .level_in(!ship_pin_in),
    .done_out(pin_low_qual)
  );

  cmc_qual #(
    .CYCLES(QUAL_CYCLES)
  ) u_pin_high_qual (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .level_in(ship_pin_in),
    .done_out(pin_high_qual)
  );

  assign charge_request = charge_enable_pin_in || charge_override_bit_in;
  assign otg_request = !otg_request_pin_n_in || otg_request_bit_in;
  assign ship_fire = ship_request_bit_out && (ship_count >= SHIP_DLY_CYCLES - 32'h1);
  assign wdt_enabled = watchdog_timeout_field_in != `CMC_WDT_OFF;
  assign wdt_fire = wdt_enabled && is_active(state) && !watchdog_kick_wr_in
    && (wdt_count >= wdt_limit(watchdog_timeout_field_in) - 42'h1);
  assign limit_hit = switch_limit_select_in ? sw_current_10_in : sw_current_85_in;

  always @*
  begin
    next_state = state;
    case (state)
      `CMC_ST_SHIP:
      begin
        // Ship only ever exits to idle hold
        if (vin_qual || pin_low_qual)
          next_state = `CMC_ST_IDLE;
      end
      `CMC_ST_IDLE:
      begin
        if (!idle_hold_bit_in)
        begin
          if (otg_request)
            next_state = `CMC_ST_OTG;
          else if (charge_request)
            next_state = `CMC_ST_CHARGE;
        end
      end
      `CMC_ST_CHARGE:
      begin
        // OTG controls are ignored here
        if (idle_hold_bit_in || !charge_request)
          next_state = `CMC_ST_IDLE;
      end
      `CMC_ST_OTG:
      begin
        if (idle_hold_bit_in || !otg_request)
          next_state = `CMC_ST_IDLE;
      end
      `CMC_ST_FAULT:
      begin
        // Leaves to idle hold once the host backs off, or straight to ship on ship entry
        if (idle_hold_bit_in || (!charge_request && !otg_request))
          next_state = `CMC_ST_IDLE;
      end
      default:
        next_state = `CMC_ST_SHIP;
    endcase
    if (state != `CMC_ST_SHIP)
    begin
      if (wdt_fire && is_active(state))
        next_state = `CMC_ST_FAULT;
      // Ship entry overrides every other mode
      if (supplies_low_in || ship_fire || pin_high_qual)
        next_state = `CMC_ST_SHIP;
    end
  end

  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= `CMC_ST_SHIP;
      mode_out <= `CMC_ST_SHIP;
      ship_count <= 32'h0;
      ship_request_bit_out <= 1'b0;
      watchdog_kick_bit_out <= 1'b0;
      wdt_count <= 42'h0;
      watchdog_expired_out <= 1'b0;
      thermal_fault_flag_out <= 1'b0;
      thermal_hold <= 1'b0;
      oc_run <= 4'h0;
      cycle_tripped <= 1'b0;
      overcurrent_latch_out <= 1'b0;
      switch_off_out <= 1'b0;
      converter_enable_out <= 1'b0;
      aux_regulator_enable_out <= 1'b0;
    end
    else if (ce_in)
    begin
      state <= next_state;
      mode_out <= next_state;

      // Countdown runs only while the request bit is set; a 0 write cancels
      if (ship_request_wr_in)
      begin
        ship_request_bit_out <= ship_request_wdata_in;
        ship_count <= 32'h0;
      end
      else if (ship_fire || state == `CMC_ST_SHIP)
      begin
        ship_request_bit_out <= 1'b0;
        ship_count <= 32'h0;
      end
      else if (ship_request_bit_out)
        ship_count <= ship_count + 32'h1;

      // Kick bit reads 1 for one cycle, then clears itself
      watchdog_kick_bit_out <= watchdog_kick_wr_in;
      if (!is_active(state) || !wdt_enabled || watchdog_kick_wr_in)
        wdt_count <= 42'h0;
      else if (!wdt_fire)
        wdt_count <= wdt_count + 42'h1;
      if (wdt_fire)
        watchdog_expired_out <= 1'b1;
      else if (watchdog_kick_wr_in || !wdt_enabled || next_state == `CMC_ST_IDLE)
        watchdog_expired_out <= 1'b0;

      // Detection wins over a read in the same cycle
      if (over_temp_in)
        thermal_fault_flag_out <= 1'b1;
      else if (thermal_flag_rd_in)
        thermal_fault_flag_out <= 1'b0;
      if (over_temp_in)
        thermal_hold <= 1'b1;
      else if (temp_recovered_in)
        thermal_hold <= 1'b0;

      // Per-cycle trip memory ends at the cycle boundary
      if (cycle_end_in)
        cycle_tripped <= 1'b0;
      else if (limit_hit && is_active(state))
        cycle_tripped <= 1'b1;
      switch_off_out <= !cycle_end_in && (cycle_tripped || (limit_hit && is_active(state)));
      if (cycle_end_in)
      begin
        if (cycle_tripped && is_active(state))
          oc_run <= (oc_run == `CMC_OC_TRIPS) ? oc_run : oc_run + 4'h1;
        else
          oc_run <= 4'h0;
      end
      if (overcurrent_latch_disable_in || state == `CMC_ST_IDLE)
      begin
        overcurrent_latch_out <= 1'b0;
        oc_run <= 4'h0;
      end
      else if (cycle_end_in && cycle_tripped && oc_run == `CMC_OC_TRIPS - 4'h1)
        overcurrent_latch_out <= 1'b1;

      // Converter runs only in an active mode with no protection holding it
      converter_enable_out <= is_active(next_state) && !over_temp_in
        && !thermal_hold && !overcurrent_latch_out;
      aux_regulator_enable_out <= (next_state != `CMC_ST_SHIP) && regulator_enable_bit_in;
    end
  end
endmodule

// *** bench/cmc_monitor.sv ***
// Assertion checker for the charger mode controller
`timescale 1ns/1ps
module cmc_monitor #(
  parameter [31:0] QUAL_CYCLES = 32'd20,
  parameter [31:0] SHIP_DLY_CYCLES = 32'd50,
  parameter [39:0] WDT_UNIT_CYCLES = 40'd100
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire regulator_enable_bit_in,
  input wire idle_hold_bit_in,
  input wire watchdog_kick_wr_in,
  input wire over_temp_in,
  input wire thermal_flag_rd_in,
  input wire overcurrent_latch_disable_in,
  input wire [2:0] mode_out,
  input wire converter_enable_out,
  input wire aux_regulator_enable_out,
  input wire watchdog_kick_bit_out,
  input wire thermal_fault_flag_out,
  input wire overcurrent_latch_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  property p_ship_exit;
    mode_out == 3'h0 |=> mode_out <= 3'h1;
  endproperty
  a_ship_exit: assert property (p_ship_exit) else $error("ship left to an active mode");
  property p_charge_entry;
    !(mode_out inside {3'h1, 3'h2}) |=> mode_out != 3'h2;
  endproperty
  a_charge_entry: assert property (p_charge_entry) else $error("charge not from idle");
  property p_idle_conv;
    mode_out == 3'h1 |-> !converter_enable_out;
  endproperty
  a_idle_conv: assert property (p_idle_conv) else $error("converter on in idle");
  property p_aux;
    mode_out == 3'h1 ##1 mode_out == 3'h1 |->
      aux_regulator_enable_out == $past(regulator_enable_bit_in);
  endproperty
  a_aux: assert property (p_aux) else $error("aux regulator not following bit");
  property p_hold_blocks;
    idle_hold_bit_in && mode_out == 3'h1 |=> !(mode_out inside {3'h2, 3'h3});
  endproperty
  a_hold_blocks: assert property (p_hold_blocks) else $error("hold bit ignored");
  property p_kick;
    watchdog_kick_wr_in ##1 !watchdog_kick_wr_in |->
      watchdog_kick_bit_out ##1 !watchdog_kick_bit_out;
  endproperty
  a_kick: assert property (p_kick) else $error("kick bit not self clearing");
  property p_tsd;
    over_temp_in |=> thermal_fault_flag_out && !converter_enable_out;
  endproperty
  a_tsd: assert property (p_tsd) else $error("thermal shutdown missed");
  property p_tsd_sticky;
    thermal_fault_flag_out && !thermal_flag_rd_in |=> thermal_fault_flag_out;
  endproperty
  a_tsd_sticky: assert property (p_tsd_sticky) else $error("thermal flag lost");
  property p_fault_conv;
    mode_out == 3'h4 |-> !converter_enable_out;
  endproperty
  a_fault_conv: assert property (p_fault_conv) else $error("converter on in fault");
  property p_ocl_clear;
    overcurrent_latch_disable_in |=> !overcurrent_latch_out;
  endproperty
  a_ocl_clear: assert property (p_ocl_clear) else $error("latch not cleared");
  c_charge: cover property (mode_out == 3'h2);
  c_fault: cover property (mode_out == 3'h4);
  c_reship: cover property (mode_out == 3'h1 ##1 mode_out == 3'h0);
endmodule
bind cmc_top cmc_monitor #(.QUAL_CYCLES(QUAL_CYCLES), .SHIP_DLY_CYCLES(SHIP_DLY_CYCLES),
  .WDT_UNIT_CYCLES(WDT_UNIT_CYCLES)) i_mon (.*);

// *** bench/cmc_host.sv ***
// Host controller model: control bits, pins and host write pulses
`timescale 1ns/1ps
module cmc_host (
  input wire ref_clk_in,
  output logic chg_pin_out = 1'b0,
  output logic ovr_bit_out = 1'b0,
  output logic hold_bit_out = 1'b0,
  output logic otg_bit_out = 1'b0,
  output logic otg_pin_n_out = 1'b1,
  output logic ship_wr_out = 1'b0,
  output logic ship_wdata_out = 1'b0,
  output logic kick_wr_out = 1'b0
);
  // Charge, override, hold and OTG requests change together
  task set_req(input logic chg, ovr, hold, otgb, otgn);
    @(negedge ref_clk_in);
    {chg_pin_out, ovr_bit_out, hold_bit_out, otg_bit_out, otg_pin_n_out} = {chg, ovr, hold, otgb, otgn};
  endtask
  task ship_wr(input logic d);
    @(negedge ref_clk_in);
    ship_wr_out = 1'b1;
    ship_wdata_out = d;
    @(negedge ref_clk_in);
    ship_wr_out = 1'b0;
  endtask
  task kick;
    @(negedge ref_clk_in);
    kick_wr_out = 1'b1;
    @(negedge ref_clk_in);
    kick_wr_out = 1'b0;
  endtask
endmodule

// *** bench/test_charger_mode_controller.sv ***
// Self-checking testbench for the charger mode controller
`timescale 1ns/1ps
module test_charger_mode_controller;
  logic ref_clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, vin_valid_in = 1'b0;
  logic supplies_low_in = 1'b0, ship_pin_in = 1'b0, regulator_enable_bit_in = 1'b0;
  logic switch_limit_select_in = 1'b0, overcurrent_latch_disable_in = 1'b0;
  logic over_temp_in = 1'b0, temp_recovered_in = 1'b0, thermal_flag_rd_in = 1'b0;
  logic cycle_end_in = 1'b0, sw_current_85_in = 1'b0, sw_current_10_in = 1'b0;
  logic [1:0] watchdog_timeout_field_in = 2'h0;
  wire charge_enable_pin_in, otg_request_pin_n_in, otg_request_bit_in, charge_override_bit_in;
  wire idle_hold_bit_in, ship_request_wr_in, ship_request_wdata_in, watchdog_kick_wr_in;
  wire [2:0] mode_out;
  wire converter_enable_out, switch_off_out, aux_regulator_enable_out, ship_request_bit_out;
  wire watchdog_kick_bit_out, watchdog_expired_out, thermal_fault_flag_out;
  wire overcurrent_latch_out;
  integer failures = 0, checked = 0;
  // Short counts: qualify 20, ship delay 50, watchdog unit 100 cycles
  cmc_top #(.QUAL_CYCLES(32'd20), .SHIP_DLY_CYCLES(32'd50), .WDT_UNIT_CYCLES(40'd100)) i_dut (.*);
  cmc_host i_host (.ref_clk_in(ref_clk_in), .chg_pin_out(charge_enable_pin_in),
    .ovr_bit_out(charge_override_bit_in), .hold_bit_out(idle_hold_bit_in),
    .otg_bit_out(otg_request_bit_in), .otg_pin_n_out(otg_request_pin_n_in),
    .ship_wr_out(ship_request_wr_in), .ship_wdata_out(ship_request_wdata_in),
    .kick_wr_out(watchdog_kick_wr_in));
  initial forever #5 ref_clk_in = ~ref_clk_in;
  task print_verdict;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    checked = checked + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wait_mode(input logic [2:0] m, input integer lim);
    integer i;
    i = 0;
    while (mode_out !== m && i < lim)
    begin
      @(negedge ref_clk_in);
      i = i + 1;
    end
    chk(mode_out, m);
    if (mode_out !== m) print_verdict;
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  initial
  begin
    cyc(8);
    rst_in = 1'b0;
    wait_mode(3'h1, 40);
    regulator_enable_bit_in = 1'b1;
    cyc(30);
    chk(mode_out, 3'h1);
    chk(aux_regulator_enable_out, 1'b1);
    i_host.set_req(1, 0, 1, 0, 1);
    cyc(10);
    chk(mode_out, 3'h1);
    i_host.set_req(1, 0, 0, 0, 1);
    wait_mode(3'h2, 5);
    i_host.set_req(1, 0, 0, 1, 0);
    cyc(5);
    chk(mode_out, 3'h2);
    i_host.set_req(1, 0, 1, 1, 0);
    wait_mode(3'h1, 5);
    i_host.set_req(1, 0, 0, 0, 0);
    wait_mode(3'h3, 5);
    i_host.set_req(0, 0, 0, 0, 1);
    wait_mode(3'h1, 5);
    i_host.set_req(0, 1, 0, 0, 1);
    wait_mode(3'h2, 5);
    over_temp_in = 1'b1;
    cyc(2);
    chk({thermal_fault_flag_out, converter_enable_out}, 4'h2);
    over_temp_in = 1'b0;
    temp_recovered_in = 1'b1;
    cyc(5);
    chk({thermal_fault_flag_out, converter_enable_out}, 4'h3);
    thermal_flag_rd_in = 1'b1;
    cyc(1);
    thermal_flag_rd_in = 1'b0;
    cyc(1);
    chk(thermal_fault_flag_out, 1'b0);
    switch_limit_select_in = 1'b1;
    sw_current_85_in = 1'b1;
    cyc(2);
    chk(switch_off_out, 1'b0);
    sw_current_10_in = 1'b1;
    cyc(1);
    chk(switch_off_out, 1'b1);
    // Seven tripped cycles must not latch yet; the eighth must
    repeat (7)
    begin
      cycle_end_in = 1'b1;
      cyc(1);
      cycle_end_in = 1'b0;
      cyc(1);
    end
    chk(overcurrent_latch_out, 1'b0);
    cycle_end_in = 1'b1;
    cyc(1);
    cycle_end_in = 1'b0;
    cyc(1);
    chk({overcurrent_latch_out, converter_enable_out}, 4'h2);
    sw_current_85_in = 1'b0;
    sw_current_10_in = 1'b0;
    cycle_end_in = 1'b1;
    overcurrent_latch_disable_in = 1'b1;
    cyc(1);
    cycle_end_in = 1'b0;
    cyc(1);
    chk({overcurrent_latch_out, converter_enable_out}, 4'h1);
    chk(switch_off_out, 1'b0);
    overcurrent_latch_disable_in = 1'b0;
    watchdog_timeout_field_in = 2'h1;
    i_host.kick();
    chk(watchdog_kick_bit_out, 1'b1);
    cyc(1);
    chk(watchdog_kick_bit_out, 1'b0);
    cyc(90);
    chk(mode_out, 3'h2);
    wait_mode(3'h4, 20);
    chk(watchdog_expired_out, 1'b1);
    chk(converter_enable_out, 1'b0);
    i_host.set_req(0, 0, 0, 0, 1);
    wait_mode(3'h1, 5);
    chk(watchdog_expired_out, 1'b0);
    // Enable low freezes state, so this write is never taken
    ce_in = 1'b0;
    i_host.ship_wr(1);
    cyc(3);
    chk(ship_request_bit_out, 1'b0);
    ce_in = 1'b1;
    i_host.ship_wr(1);
    chk(ship_request_bit_out, 1'b1);
    cyc(20);
    i_host.ship_wr(0);
    chk(ship_request_bit_out, 1'b0);
    cyc(60);
    chk(mode_out, 3'h1);
    i_host.ship_wr(1);
    cyc(45);
    chk(mode_out, 3'h1);
    wait_mode(3'h0, 20);
    chk(ship_request_bit_out, 1'b0);
    // Pin-high qualify pulses once; it must run outside ship to count
    vin_valid_in = 1'b1;
    wait_mode(3'h1, 40);
    vin_valid_in = 1'b0;
    ship_pin_in = 1'b1;
    wait_mode(3'h0, 40);
    ship_pin_in = 1'b0;
    wait_mode(3'h1, 40);
    supplies_low_in = 1'b1;
    wait_mode(3'h0, 5);
    print_verdict;
  end
endmodule
